// >>> rtl/sas_sequencer.sv
// sar adc sequencer: mode register, sequencing, approximation, result slots
//
// Summary of operation
// RULE1: one of eight inputs routed by mode
// RULE2: binary search, top bit first, keep if greater
// RULE3: finished value copied to next result slot
// RULE4: completion flag after all four slots filled
// RULE5: mode bit0 select, bits1-3 input, bit4 speed
// RULE6: conversion lasts 192 or 144 states
// RULE7: software picks speed by oscillator frequency
// RULE8: mode register reads back stored contents
// RULE9: reset or hardware stop clears mode
// RULE10: mode write restarts conversion from slot zero
// RULE11: after write, next flag means fresh results
// RULE12: mode bit zero scan, one select
// RULE13: scan group chosen by top select bit
// RULE14: select mode decodes field as channel number
// RULE15: upper inputs flag falling edges independently
// RULE16: scan converts group ascending into matching slots
// RULE17: scan restarts at first input after four
// RULE18: select rotates one input through four slots
// RULE19: mask blocks interrupt, flag still sets
// RULE20: sampling phase then eight equal steps
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sas_sequencer (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // hardware stop request
    input wire logic HW_STOP,
    // axi4-lite write address
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    // axi4-lite write data
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // axi4-lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // axi4-lite read address
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    // axi4-lite read data
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // analog front end
    output logic [2:0] MUX_SEL,
    output logic [7:0] TAP,
    output logic SAMPLE_HOLD,
    input wire logic COMP_GT,
    // upper analog inputs as digital levels
    input wire logic [3:0] AN_HI_LEVEL,
    // conversion done and falling-edge flags
    output logic CONVERSION_DONE_IRQ,
    output logic [3:0] EDGE_FLAGS
);
    import sas_pkg::*;

    sas_state_t s_r;
    sas_state_t s_nxt;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_mode;
    logic store;
    logic step_end;
    logic [7:0] sar_dec;
    logic [3:0] fall;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] step_len(input logic fr);
        step_len = fr ? STEP_FAST_CNT : STEP_SLOW_CNT; // RULE6
    endfunction : step_len

    function automatic logic [7:0] sample_len(input logic fr);
        sample_len = fr ? SAMPLE_FAST_CNT : SAMPLE_SLOW_CNT; // RULE20
    endfunction : sample_len

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = a & ADDR_WORD_MASK;
        is_mapped = (w == ADDR_MODE) || (w == ADDR_RES0) || (w == ADDR_RES1) ||
                    (w == ADDR_RES2) || (w == ADDR_RES3) || (w == ADDR_STATUS) ||
                    (w == ADDR_MASK);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes

    assign S_AXI_AWREADY = !s_r.aw_got && !s_r.bvalid;
    assign S_AXI_WREADY = !s_r.w_got && !s_r.bvalid;
    assign S_AXI_ARREADY = !s_r.rvalid;
    assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_addr = s_r.aw_got ? s_r.awaddr : S_AXI_AWADDR;
    assign wr_data = s_r.w_got ? s_r.wdata : S_AXI_WDATA;
    assign wr_strb = s_r.w_got ? s_r.wstrb : S_AXI_WSTRB;
    assign wr_go = (s_r.aw_got || aw_fire) && (s_r.w_got || w_fire) && !s_r.bvalid;
    assign wr_mode = wr_go && ((wr_addr & ADDR_WORD_MASK) == ADDR_MODE);

    ////////////////////////////////////////////////////////////////////////
    // sequencer decode

    assign step_end = (s_r.phase == PH_STEP) &&
                      (s_r.cnt == 8'(step_len(s_r.mode[MODE_FR_BIT]) - 8'h01));
    assign store = step_end && (s_r.bit_idx == 3'h0);
    assign fall = s_r.an_s3 & ~s_r.an_s2; // RULE15

    always_comb begin
        sar_dec = s_r.approximation_register;
        sar_dec[s_r.bit_idx] = s_r.comp_s2; // RULE2
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [2:0] bit_lo;
        logic [7:0] w;
        bit_lo = 3'(s_r.bit_idx - 3'h1);
        w = 8'h00;
        s_nxt = s_r;

        // synchronisers
        s_nxt.comp_s1 = COMP_GT;
        s_nxt.comp_s2 = s_r.comp_s1;
        s_nxt.an_s1 = AN_HI_LEVEL;
        s_nxt.an_s2 = s_r.an_s1;
        s_nxt.an_s3 = s_r.an_s2;

        // write channel
        if (s_r.bvalid && S_AXI_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            w = wr_addr & ADDR_WORD_MASK;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            if (wr_strb[WSTRB_LOW]) begin
                unique case (w)
                    ADDR_MODE: s_nxt.mode = wr_data[7:0]; // RULE5
                    ADDR_MASK: s_nxt.mask = wr_data[MASK_IRQ_BIT];
                    ADDR_STATUS: begin
                        // write one to clear; sets below win
                        if (wr_data[STAT_DONE_BIT]) begin
                            s_nxt.done = 1'b0;
                        end
                        s_nxt.edges = s_r.edges & ~wr_data[STAT_EDGE_LSB +: EDGE_N];
                    end
                    default: ;
                endcase
            end
        end else begin
            if (aw_fire) begin
                s_nxt.aw_got = 1'b1;
                s_nxt.awaddr = S_AXI_AWADDR;
            end
            if (w_fire) begin
                s_nxt.w_got = 1'b1;
                s_nxt.wdata = S_AXI_WDATA;
                s_nxt.wstrb = S_AXI_WSTRB;
            end
        end

        // read channel
        if (s_r.rvalid && S_AXI_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_fire) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            unique case (S_AXI_ARADDR & ADDR_WORD_MASK)
                ADDR_MODE: s_nxt.rdata[7:0] = s_r.mode; // RULE8
                ADDR_RES0: s_nxt.rdata[7:0] = s_r.result[0];
                ADDR_RES1: s_nxt.rdata[7:0] = s_r.result[1];
                ADDR_RES2: s_nxt.rdata[7:0] = s_r.result[2];
                ADDR_RES3: s_nxt.rdata[7:0] = s_r.result[3];
                ADDR_STATUS: begin
                    s_nxt.rdata[STAT_DONE_BIT] = s_r.done;
                    s_nxt.rdata[STAT_EDGE_LSB +: EDGE_N] = s_r.edges;
                end
                ADDR_MASK: s_nxt.rdata[MASK_IRQ_BIT] = s_r.mask;
                default: ;
            endcase
        end

        // hardware stop overrides any mode write
        if (HW_STOP) begin
            s_nxt.mode = MODE_RESET; // RULE9
        end

        // conversion sequencing
        if (HW_STOP || wr_mode) begin
            // abandon conversion, restart at first step and slot
            s_nxt.phase = PH_SAMPLE; // RULE10 RULE11
            s_nxt.cnt = 8'h00;
            s_nxt.bit_idx = BIT_TOP;
            s_nxt.approximation_register = 8'h00;
            s_nxt.slot = 2'h0;
        end else if (s_r.phase == PH_SAMPLE) begin
            if (s_r.cnt == 8'(sample_len(s_r.mode[MODE_FR_BIT]) - 8'h01)) begin
                s_nxt.phase = PH_STEP; // RULE20
                s_nxt.cnt = 8'h00;
                s_nxt.bit_idx = BIT_TOP;
                s_nxt.approximation_register = SAR_TRIAL_TOP; // RULE2
            end else begin
                s_nxt.cnt = 8'(s_r.cnt + 8'h01);
            end
        end else if (step_end) begin
            s_nxt.cnt = 8'h00;
            s_nxt.approximation_register = sar_dec; // RULE2
            if (store) begin
                s_nxt.result[s_r.slot] = sar_dec; // RULE3 RULE18
                s_nxt.slot = 2'(s_r.slot + 2'h1); // RULE16 RULE17
                s_nxt.phase = PH_SAMPLE;
            end else begin
                s_nxt.bit_idx = bit_lo;
                s_nxt.approximation_register[bit_lo] = 1'b1; // RULE2
            end
        end else begin
            s_nxt.cnt = 8'(s_r.cnt + 8'h01);
        end

        // hardware sets win over software clears
        if (store && (s_r.slot == SLOT_LAST)) begin
            s_nxt.done = 1'b1; // RULE4
        end
        s_nxt.edges = s_nxt.edges | fall; // RULE15

        // input routing
        if (s_nxt.mode[MODE_MS_BIT]) begin
            s_nxt.mux_sel = s_nxt.mode[MODE_SEL_MSB:MODE_SEL_LSB]; // RULE1 RULE12 RULE14
        end else begin
            s_nxt.mux_sel = {s_nxt.mode[MODE_SEL_MSB], s_nxt.slot}; // RULE12 RULE13 RULE16
        end
        s_nxt.irq = s_nxt.done && !s_nxt.mask; // RULE19
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign S_AXI_BVALID = s_r.bvalid;
    assign S_AXI_BRESP = s_r.bresp;
    assign S_AXI_RVALID = s_r.rvalid;
    assign S_AXI_RDATA = s_r.rdata;
    assign S_AXI_RRESP = s_r.rresp;
    assign MUX_SEL = s_r.mux_sel;
    assign TAP = s_r.approximation_register;
    assign SAMPLE_HOLD = (s_r.phase == PH_SAMPLE);
    assign CONVERSION_DONE_IRQ = s_r.irq;
    assign EDGE_FLAGS = s_r.edges;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] conv_cnt_r;

    // cycles since the last conversion began
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            conv_cnt_r <= 8'h00;
        end else if (store || wr_mode || HW_STOP) begin
            conv_cnt_r <= 8'h00;
        end else begin
            conv_cnt_r <= 8'(conv_cnt_r + 8'h01);
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_mode_write;
        wr_mode && !HW_STOP;
    endsequence

    sequence s_slot_store;
        store && !wr_mode && !HW_STOP;
    endsequence

    a_stop_clears_mode: assert property ( // RULE9
        HW_STOP |=> (s_r.mode == MODE_RESET) && (s_r.slot == 2'h0))
        else $error("mode not cleared by hardware stop");

    a_mode_readback: assert property ( // RULE8
        (ar_fire && ((S_AXI_ARADDR & ADDR_WORD_MASK) == ADDR_MODE))
        |=> S_AXI_RVALID && (S_AXI_RDATA[7:0] == $past(s_r.mode)))
        else $error("mode read returned wrong value");

    a_write_restarts: assert property ( // RULE10
        s_mode_write |=> (s_r.phase == PH_SAMPLE) && (s_r.cnt == 8'h00) &&
        (s_r.slot == 2'h0) ##1 (s_r.cnt == 8'h01))
        else $error("mode write did not restart sequencing");

    a_conv_length: assert property ( // RULE6
        s_slot_store |-> (conv_cnt_r == 8'(s_r.mode[MODE_FR_BIT] ?
        STATES_FAST - 1 : STATES_SLOW - 1)))
        else $error("conversion length wrong");

    a_slot_advance: assert property ( // RULE3
        s_slot_store |=> (s_r.slot == 2'($past(s_r.slot) + 2'h1)) &&
        (s_r.result[$past(s_r.slot)] == $past(sar_dec)))
        else $error("result slot not filled in order");

    a_done_after_four: assert property ( // RULE4
        (s_slot_store and (s_r.slot == SLOT_LAST)) |=> s_r.done ##1 s_r.done)
        else $error("completion flag missing after fourth slot");

    a_binary_step: assert property ( // RULE2
        (step_end && (s_r.bit_idx != 3'h0) && !wr_mode && !HW_STOP) |=>
        (s_r.approximation_register[$past(s_r.bit_idx)] == $past(s_r.comp_s2)) && s_r.approximation_register[s_r.bit_idx] &&
        (s_r.bit_idx == 3'($past(s_r.bit_idx) - 3'h1)))
        else $error("approximation step wrong");

    a_input_routing: assert property ( // RULE13
        MUX_SEL == (s_r.mode[MODE_MS_BIT] ? s_r.mode[MODE_SEL_MSB:MODE_SEL_LSB] :
        {s_r.mode[MODE_SEL_MSB], s_r.slot}))
        else $error("input routing does not match mode");

    a_mask_gates_irq: assert property ( // RULE19
        s_r.mask |-> !CONVERSION_DONE_IRQ)
        else $error("masked interrupt reached output");

    a_edge_flags_set: assert property ( // RULE15
        (fall != 4'h0) |=> ((s_r.edges & $past(fall)) == $past(fall)))
        else $error("falling edge not flagged");

endmodule : sas_sequencer

// >>> rtl/sas_pkg.sv
// constants, types and state layout for the sar adc sequencer
package sas_pkg;

    // register byte addresses (one aligned 32-bit word each)
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_RES0 = 8'h04;
    localparam logic [7:0] ADDR_RES1 = 8'h08;
    localparam logic [7:0] ADDR_RES2 = 8'h0C;
    localparam logic [7:0] ADDR_RES3 = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;

    // mode register layout
    localparam int MODE_MS_BIT = 0;
    localparam int MODE_SEL_LSB = 1;
    localparam int MODE_SEL_MSB = 3;
    localparam int MODE_FR_BIT = 4;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // status and mask layout
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_EDGE_LSB = 1;
    localparam int EDGE_N = 4;
    localparam int MASK_IRQ_BIT = 0;
    localparam int WSTRB_LOW = 0;

    // conversion timing in states (one state = one clock)
    localparam int STATES_SLOW = 192;
    localparam int STATES_FAST = 144;
    localparam int STEPS = 8;
    localparam int STEP_SLOW = 16;
    localparam int STEP_FAST = 12;
    localparam logic [7:0] STEP_SLOW_CNT = 8'(STEP_SLOW);
    localparam logic [7:0] STEP_FAST_CNT = 8'(STEP_FAST);
    localparam logic [7:0] SAMPLE_SLOW_CNT = 8'(STATES_SLOW - STEPS * STEP_SLOW);
    localparam logic [7:0] SAMPLE_FAST_CNT = 8'(STATES_FAST - STEPS * STEP_FAST);
    localparam logic [2:0] BIT_TOP = 3'(STEPS - 1);
    localparam logic [7:0] SAR_TRIAL_TOP = 8'h80;
    localparam logic [1:0] SLOT_LAST = 2'h3;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {PH_SAMPLE, PH_STEP} sas_phase_t;

    typedef struct packed {
        logic [7:0] mode;
        logic mask;
        logic done;
        logic [3:0] edges;
        logic [3:0][7:0] result;
        logic [7:0] approximation_register;
        logic [1:0] slot;
        sas_phase_t phase;
        logic [2:0] bit_idx;
        logic [7:0] cnt;
        logic [2:0] mux_sel;
        logic irq;
        logic comp_s1;
        logic comp_s2;
        logic [3:0] an_s1;
        logic [3:0] an_s2;
        logic [3:0] an_s3;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sas_state_t;

    localparam sas_state_t STATE_RESET = '0;

endpackage : sas_pkg

// >>> test/sas_analog_model.sv
// analog front end model: input multiplexer and comparator
`timescale 1ns/1ps
module sas_analog_model (
    // selection from the sequencer
    input wire logic [2:0] mux_sel,
    input wire logic [7:0] tap,
    // input levels as codes
    input wire logic [7:0][7:0] level,
    // comparator
    output logic comp_gt
);
    // high only when the chosen input is strictly above the tap
    assign comp_gt = level[mux_sel] > tap;
endmodule : sas_analog_model

// >>> test/testbench.sv
// self-checking bench for the sar adc sequencer
`timescale 1ns/1ps
module testbench;
    import sas_pkg::*;
    logic MCLK = 1'h0;
    logic RESET_N = 1'h0;
    logic HW_STOP = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] an_hi = 4'hF;
    logic [7:0][7:0] vin = '0;
    logic awready, wready, bvalid, arready, rvalid, sh, comp, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] mux_sel;
    logic [7:0] tap;
    logic [3:0] edges;
    int miscompares = 0;
    int checked = 0;

    always #5 MCLK = ~MCLK;

    sas_sequencer i_dut (
        .MCLK(MCLK), .RESET_N(RESET_N), .HW_STOP(HW_STOP),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .MUX_SEL(mux_sel), .TAP(tap),
        .SAMPLE_HOLD(sh), .COMP_GT(comp), .AN_HI_LEVEL(an_hi),
        .CONVERSION_DONE_IRQ(irq), .EDGE_FLAGS(edges)
    );

    sas_analog_model i_model (.mux_sel(mux_sel), .tap(tap), .level(vin), .comp_gt(comp));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // handshakes judged at the falling edge, released after the rising one
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, b;
        int n;
        @(posedge MCLK);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b = 1'h0;
        n = 0;
        while (!b && n < 1000) begin
            @(negedge MCLK);
            ta = awvalid && awready;
            tw = wvalid && wready;
            b = bvalid;
            r = bresp;
            n++;
            @(posedge MCLK);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        if (!b) miscompares++;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, v;
        int n;
        @(posedge MCLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        v = 1'h0;
        n = 0;
        while (!v && n < 1000) begin
            @(negedge MCLK);
            ta = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            n++;
            @(posedge MCLK);
            if (ta) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        if (!v) miscompares++;
    endtask : axi_read

    function automatic logic [7:0] sar_exp(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (v > (r | (8'h01 << b))) r = r | (8'h01 << b);
        end
        return r;
    endfunction : sar_exp

    function automatic logic [2:0] exp_ch(input logic [7:0] m, input int s);
        return m[MODE_MS_BIT] ? m[MODE_SEL_MSB:MODE_SEL_LSB] : {m[MODE_SEL_MSB], 2'(s)};
    endfunction : exp_ch

    // cycles between two starts of sampling
    task automatic conv_len(output int n);
        logic p;
        int r;
        r = 0;
        n = 0;
        p = sh;
        for (int k = 0; k < 1200 && r < 2; k++) begin
            @(negedge MCLK);
            if (sh && !p) r++;
            if (r == 1) n++;
            p = sh;
        end
    endtask : conv_len

    // new levels, mode write, wait for four fresh results
    task automatic run_case(input logic [7:0] m);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        @(posedge MCLK);
        foreach (vin[i]) vin[i] <= 8'($urandom);
        axi_write(ADDR_MODE, {24'h0, m}, r);
        #1 chk({29'h0, mux_sel}, {29'h0, exp_ch(m, 0)});
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        axi_write(ADDR_STATUS, 32'h1, r);
        axi_read(ADDR_MODE, d, r);
        chk(d, {24'h0, m});
        n = 0;
        do begin
            @(negedge MCLK);
            n++;
        end while (!irq && n < 2000);
        chk({31'h0, irq}, 32'h1);
        chk({29'h0, mux_sel}, {29'h0, exp_ch(m, 0)});
        for (int s = 0; s < 4; s++) begin
            axi_read(ADDR_RES0 + 8'(4 * s), d, r);
            chk(d, {24'h0, sar_exp(vin[exp_ch(m, s)])});
        end
    endtask : run_case

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n, k;
        void'($urandom(76));
        repeat (20) @(posedge MCLK);
        RESET_N <= 1'h1;
        axi_read(ADDR_MODE, d, r);
        chk(d, 32'h0);
        axi_read(8'h1C, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(8'h1C, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        conv_len(n);
        chk(32'(n), 32'(STATES_SLOW));
        axi_write(ADDR_MODE, 32'h10, r);
        conv_len(n);
        chk(32'(n), 32'(STATES_FAST));
        run_case(8'h10);
        run_case(8'h18);
        run_case(8'h08);
        run_case(8'hE0);
        for (k = 0; k < 8; k++) begin
            run_case(8'h01 | 8'(k << 1) | 8'(($urandom % 2) << 4));
        end
        // masked: flag sets, request stays low
        axi_write(ADDR_MASK, 32'h1, r);
        axi_write(ADDR_STATUS, 32'h1, r);
        n = 0;
        repeat (900) begin
            @(negedge MCLK);
            if (irq) n++;
        end
        chk(32'(n), 32'h0);
        axi_read(ADDR_STATUS, d, r);
        chk({31'h0, d[STAT_DONE_BIT]}, 32'h1);
        axi_write(ADDR_MASK, 32'h0, r);
        @(negedge MCLK);
        chk({31'h0, irq}, 32'h1);
        // falling edge on one upper input
        k = $urandom % 4;
        @(posedge MCLK);
        an_hi[k] <= 1'h0;
        repeat (5) @(negedge MCLK);
        chk({28'h0, edges}, 32'(1 << k));
        axi_write(ADDR_STATUS, 32'(2 << k), r);
        @(negedge MCLK);
        chk({28'h0, edges}, 32'h0);
        // hardware stop clears the mode
        @(posedge MCLK);
        HW_STOP <= 1'h1;
        repeat (3) @(posedge MCLK);
        HW_STOP <= 1'h0;
        axi_read(ADDR_MODE, d, r);
        chk(d, 32'h0);
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge MCLK);
        miscompares++;
        end_of_test();
    end
endmodule : testbench
